// ===== rtl/optical_ctl.sv
// Transmit-off, laser fault and loss-of-signal control with diagnostic byte
//
// Functional notes
// - Transmit-off input high shuts laser off.
// - Transmit-off input defaults high, laser off.
// - Soft off bit 6, off state bit 7.
// - Laser off when soft or hard off.
// - Catastrophic fault disables laser, raises fault.
// - Fault latched until toggle or power cycle.
// - Fault mirrored in diagnostic bit 2.
// - Unsafe output power disables laser, raises fault.
// - Signal loss from receive transition detection.
// - Loss output low adequate, high unusable.
// - Loss mirrored in diagnostic bit 1.
`timescale 1ns/1ns
`include "optical_ctl_defines.svh"
module optical_ctl
  import optical_ctl_pkg::*;
#(
  parameter int unsigned LOS_WINDOW = `LOS_WINDOW_CYCLES,
  parameter bit          DIAG_EN    = 1'b1
) (
  input  wire logic       sys_clk,          // System clock, 25 MHz
  input  wire logic       arst_n,           // Asynchronous reset, active low
  input  wire logic       txoff_pin,        // Transmit-off request pin (pulled high)
  input  wire logic       rx_data,          // Quantised receive data
  input  wire logic       laser_fault_det,  // Catastrophic laser fault detector
  input  wire logic       power_unsafe_det, // Eye-safety power monitor trip
  input  wire logic       diag_wr,          // Diagnostic byte write strobe
  input  wire logic       diag_rd,          // Diagnostic byte read strobe
  input  wire logic [7:0] diag_addr,        // Diagnostic byte address
  input  wire logic [7:0] diag_wdata,       // Diagnostic write data
  output logic      [7:0] diag_rdata,       // Diagnostic read data
  output logic            laser_enable,     // Laser driver enable
  output logic            tx_fault_oe,      // Fault open-drain enable low-release
  output logic            tx_fault,         // Fault level
  output logic            optical_input_lost // Loss-of-signal output
);

  localparam int LOSW = $clog2(LOS_WINDOW + 1);

  pin_sync_if sync ();

  laser_state_t   state_q;
  logic           soft_off_q;
  logic           hard_off;
  logic           tx_off;
  logic           fault_det;
  logic [LOSW-1:0] quiet_cnt_q;
  logic           los_q;
  logic           sel;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  pin_sync u_sync (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .txoff_raw (txoff_pin),
    .rx_raw    (rx_data),
    .fault_raw (laser_fault_det | power_unsafe_det),
    .sync      (sync)
  );

  function automatic logic hit(input logic [7:0] a);
    hit = (a == `DIAG_CTRL_STAT_OFFSET);
  endfunction

  // Latched fault, whether still waiting for the pin toggle or not
  function automatic logic faulted(input laser_state_t s);
    faulted = (s == LASER_FAULT) || (s == LASER_HELD);
  endfunction

  assign sel       = hit(diag_addr);
  assign hard_off  = sync.txoff_pin;
  assign tx_off    = hard_off | soft_off_q;
  assign fault_det = sync.fault_pin;

  // ----------------------------------------------------------------
  // Software transmit-off bit
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_off_q <= 1'b0;
    end else if (diag_wr && sel) begin
      soft_off_q <= diag_wdata[`DIAG_TXOFF_SOFT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Laser state: off, on, latched fault, fault held off awaiting release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= LASER_OFF;
    end else begin
      unique case (state_q)
        LASER_OFF: begin
          if (!tx_off) begin
            state_q <= LASER_ON;
          end
        end
        LASER_ON: begin
          if (fault_det) begin
            state_q <= LASER_FAULT;
          end else if (tx_off) begin
            state_q <= LASER_OFF;
          end
        end
        LASER_FAULT: begin
          if (hard_off) begin
            state_q <= LASER_HELD;
          end
        end
        LASER_HELD: begin
          if (!hard_off) begin
            state_q <= fault_det ? LASER_FAULT : LASER_OFF;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Loss of signal: no receive transition within the window
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet_cnt_q <= '0;
      los_q       <= 1'b1;
    end else if (sync.rx_edge) begin
      quiet_cnt_q <= '0;
      los_q       <= 1'b0;
    end else if (quiet_cnt_q >= LOSW'(LOS_WINDOW)) begin
      los_q       <= 1'b1;
    end else begin
      quiet_cnt_q <= quiet_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      laser_enable       <= 1'b0;
      tx_fault           <= 1'b0;
      tx_fault_oe        <= 1'b0;
      optical_input_lost <= 1'b1;
    end else begin
      laser_enable       <= (state_q == LASER_ON) && !tx_off && !fault_det;
      tx_fault           <= faulted(state_q);
      tx_fault_oe        <= !faulted(state_q);
      optical_input_lost <= los_q;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic byte read
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      diag_rdata <= `DIAG_RESET_VALUE;
    end else if (diag_rd) begin
      diag_rdata <= 8'h00;
      if (sel) begin
        diag_rdata[`DIAG_TXOFF_STATE_BIT] <= tx_off;
        diag_rdata[`DIAG_TXOFF_SOFT_BIT]  <= soft_off_q;
        diag_rdata[`DIAG_FAULT_BIT]       <= faulted(state_q);
        diag_rdata[`DIAG_LOS_BIT]         <= DIAG_EN & los_q;
      end
    end
  end

endmodule

// ===== rtl/optical_ctl_defines.svh
// Offsets, field positions, reset values and timing counts of the optical control block
`ifndef OPTICAL_CTL_DEFINES_SVH
`define OPTICAL_CTL_DEFINES_SVH

`define DIAG_CTRL_STAT_OFFSET 8'h6e
`define DIAG_TXOFF_STATE_BIT  7
`define DIAG_TXOFF_SOFT_BIT   6
`define DIAG_FAULT_BIT        2
`define DIAG_LOS_BIT          1
`define DIAG_RESET_VALUE      8'h00
`define SYS_CLK_HZ            25000000
`define LOS_WINDOW_US         10
`define LOS_WINDOW_CYCLES     ((`LOS_WINDOW_US * (`SYS_CLK_HZ / 1000000)))

`endif

// ===== rtl/optical_ctl_pkg.sv
// Types shared by the optical control block
package optical_ctl_pkg;

  typedef enum logic [1:0] {
    LASER_OFF   = 2'b00,
    LASER_ON    = 2'b01,
    LASER_FAULT = 2'b10,
    LASER_HELD  = 2'b11
  } laser_state_t;

endpackage

// ===== rtl/pin_sync_if.sv
// Synchronised pin levels and the receive edge pulse handed from the synchroniser to the control logic
`timescale 1ns/1ns
interface pin_sync_if;
  logic txoff_pin;
  logic rx_edge;
  logic fault_pin;
  modport src (output txoff_pin, output rx_edge, output fault_pin);
  modport dst (input txoff_pin, input rx_edge, input fault_pin);
endinterface

// ===== rtl/pin_sync.sv
// Three-stage synchronisers for the asynchronous module inputs
`timescale 1ns/1ns
module pin_sync (
  input  wire logic sys_clk,    // System clock
  input  wire logic arst_n,     // Asynchronous reset, active low
  input  wire logic txoff_raw,  // Transmit-off pin level
  input  wire logic rx_raw,     // Quantised receive data sample
  input  wire logic fault_raw,  // Laser or eye-safety fault detector
  pin_sync_if.src   sync        // Filtered levels and receive edge pulse
);

  logic [2:0] s0_q [3];
  logic [2:0] raw;
  logic [2:0] level_q;
  logic       rx_prev_q;

  assign raw = {fault_raw, rx_raw, txoff_raw};

  // ----------------------------------------------------------------
  // Synchroniser chains; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chain
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          // Transmit-off pin rests at its disabling level
          s0_q[g] <= (g == 0) ? 3'b111 : 3'b000;
          level_q[g] <= (g == 0) ? 1'b1 : 1'b0;
        end else begin
          s0_q[g] <= {s0_q[g][1:0], raw[g]};
          if (s0_q[g][1] == s0_q[g][2]) begin
            level_q[g] <= s0_q[g][2];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_prev_q <= 1'b0;
    end else begin
      rx_prev_q <= level_q[1];
    end
  end

  assign sync.txoff_pin = level_q[0];
  assign sync.rx_edge   = level_q[1] ^ rx_prev_q;
  assign sync.fault_pin = level_q[2];

endmodule

// ===== test/optical_ctl_sva.sv
// Port assertions for the optical control block
`timescale 1ns/1ns
module optical_ctl_sva #(
  parameter int unsigned LOS_WINDOW = 8  // Loss window in cycles
) (
  input  wire logic       sys_clk,            // System clock
  input  wire logic       arst_n,             // Reset, active low
  input  wire logic       txoff_pin,          // Transmit-off pin
  input  wire logic       rx_data,            // Receive data
  input  wire logic       laser_fault_det,    // Laser fault detector
  input  wire logic       power_unsafe_det,   // Eye-safety trip
  input  wire logic       diag_wr,            // Write strobe
  input  wire logic       diag_rd,            // Read strobe
  input  wire logic [7:0] diag_addr,          // Byte address
  input  wire logic [7:0] diag_wdata,         // Write data
  input  wire logic [7:0] diag_rdata,         // Read data
  input  wire logic       laser_enable,       // Laser enable
  input  wire logic       tx_fault_oe,        // Fault line sink enable
  input  wire logic       tx_fault,           // Fault level
  input  wire logic       optical_input_lost  // Loss-of-signal output
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic       rx_q;
  logic [5:0] quiet_q;
  always_ff @(posedge sys_clk) rx_q <= rx_data;
  // Cycles since the receive line last moved
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) quiet_q <= 6'h00;
    else if (rx_data != rx_q) quiet_q <= 6'h00;
    else if (quiet_q != 6'h3f) quiet_q <= quiet_q + 6'h01;
  end
  sequence soft_off_wr;
    diag_wr && diag_addr == 8'h6e && diag_wdata[6];
  endsequence
  sequence fault_rise;
    $rose(laser_fault_det || power_unsafe_det) ##1 (laser_fault_det || power_unsafe_det)[*4];
  endsequence
  a_pin_off: assert property (txoff_pin[*7] |-> !laser_enable)
    else $error("laser on with off pin high");
  a_soft_off: assert property (soft_off_wr |-> ##3 !laser_enable)
    else $error("laser on after soft off");
  a_fault_up: assert property (fault_rise |-> ##[0:4] tx_fault)
    else $error("fault not raised");
  a_fault_dark: assert property (tx_fault |-> !laser_enable && !tx_fault_oe)
    else $error("laser or sink active in fault");
  a_fault_clear: assert property ($fell(tx_fault) |-> !txoff_pin)
    else $error("fault cleared with pin high");
  a_flt_mirror: assert property (diag_rd && diag_addr == 8'h6e |=> diag_rdata[2] == tx_fault)
    else $error("fault bit wrong");
  a_unmapped: assert property (diag_rd && diag_addr != 8'h6e |=> diag_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_los_high: assert property (quiet_q == LOS_WINDOW + 12 |-> optical_input_lost)
    else $error("loss not raised");
  a_los_low: assert property ($changed(rx_data) ##1 $stable(rx_data)[*3] |-> ##[0:4] !optical_input_lost)
    else $error("loss not cleared");
endmodule

// ===== test/host_board.sv
// Host board model: spaced off-pin driver, pull-ups on the off pin and the fault line
`timescale 1ns/1ns
module host_board #(
  parameter int unsigned OFF_GAP = 250000  // Cycles between off-pin raises, 10 ms at 25 MHz
) (
  input  wire logic sys_clk,     // Host clock
  input  wire logic host_run,    // Host drives the off pin low
  input  wire logic tx_fault_oe, // Module sinks the fault line
  output logic      txoff_pin,   // Off pin at the module
  output logic      fault_line   // Fault line at the host
);
  int unsigned gap_q = 0;        // Cycles since the off pin last rose
  logic        pin_q = 1'b1;     // Pull-up holds the pin high from power up
  // An early request to raise the pin waits until the spacing has run out
  always @(posedge sys_clk) begin
    if (host_run) begin
      pin_q <= 1'b0;
    end else if (!pin_q && gap_q >= OFF_GAP) begin
      pin_q <= 1'b1;
    end
    if (!host_run && !pin_q && gap_q >= OFF_GAP) begin
      gap_q <= 0;
    end else if (gap_q < OFF_GAP) begin
      gap_q <= gap_q + 1;
    end
  end
  assign txoff_pin  = pin_q;
  assign fault_line = tx_fault_oe ? 1'b0 : 1'b1;
endmodule

// ===== test/optical_ctl_tb.sv
// Self-checking bench for the optical control block
`timescale 1ns/1ns
module optical_ctl_tb;
  logic       sys_clk = 1'b0, arst_n = 1'b0, host_run = 1'b0, rx_data = 1'b0;
  logic       laser_fault_det = 1'b0, power_unsafe_det = 1'b0, diag_wr = 1'b0, diag_rd = 1'b0;
  logic [7:0] diag_addr = 8'h00, diag_wdata = 8'h00, diag_rdata, rd_q;
  logic       txoff_pin, laser_enable, tx_fault_oe, tx_fault, optical_input_lost, fault_line;
  int         failures = 0, compares = 0;
  always #20 sys_clk = ~sys_clk;
  // Off-pin spacing shortened so the run stays short
  host_board #(.OFF_GAP(16)) u_host_board (
    .sys_clk     (sys_clk),
    .host_run    (host_run),
    .tx_fault_oe (tx_fault_oe),
    .txoff_pin   (txoff_pin),
    .fault_line  (fault_line)
  );
  optical_ctl #(.LOS_WINDOW(8)) u_optical_ctl (
    .sys_clk            (sys_clk),
    .arst_n             (arst_n),
    .txoff_pin          (txoff_pin),
    .rx_data            (rx_data),
    .laser_fault_det    (laser_fault_det),
    .power_unsafe_det   (power_unsafe_det),
    .diag_wr            (diag_wr),
    .diag_rd            (diag_rd),
    .diag_addr          (diag_addr),
    .diag_wdata         (diag_wdata),
    .diag_rdata         (diag_rdata),
    .laser_enable       (laser_enable),
    .tx_fault_oe        (tx_fault_oe),
    .tx_fault           (tx_fault),
    .optical_input_lost (optical_input_lost)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    diag_wr = 1'b1;
    diag_addr = a;
    diag_wdata = d;
    tick(1);
    diag_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a);
    diag_rd = 1'b1;
    diag_addr = a;
    tick(1);
    diag_rd = 1'b0;
    tick(1);
    rd_q = diag_rdata;
  endtask
  task automatic t_pin;
    tick(10);
    chk(laser_enable, 8'h00);
    host_run = 1'b1;
    tick(10);
    chk(laser_enable, 8'h01);
    host_run = 1'b0;
    tick(8);
    chk(laser_enable, 8'h00);
    rd(8'h6e);
    chk(rd_q & 8'hc4, 8'h80);
    host_run = 1'b1;
    tick(10);
  endtask
  task automatic t_soft;
    wr(8'h6e, 8'h40);
    tick(4);
    chk(laser_enable, 8'h00);
    rd(8'h6e);
    chk(rd_q & 8'hc4, 8'hc0);
    wr(8'h6e, 8'hbf);
    wr(8'h20, 8'h40);
    tick(4);
    chk(laser_enable, 8'h01);
    rd(8'h20);
    chk(rd_q, 8'h00);
  endtask
  task automatic t_fault(input logic pwr);
    laser_fault_det = !pwr;
    power_unsafe_det = pwr;
    tick(8);
    chk({tx_fault, fault_line, laser_enable}, 8'h06);
    rd(8'h6e);
    chk(rd_q & 8'hc4, 8'h04);
    laser_fault_det = 1'b0;
    power_unsafe_det = 1'b0;
    wr(8'h6e, 8'h40);
    wr(8'h6e, 8'h00);
    tick(8);
    chk(tx_fault, 8'h01);
    host_run = 1'b0;
    tick(8);
    chk(tx_fault, 8'h01);
    host_run = 1'b1;
    tick(10);
    chk({tx_fault, fault_line, laser_enable}, 8'h01);
  endtask
  task automatic t_los;
    tick(30);
    chk(optical_input_lost, 8'h01);
    rd(8'h6e);
    chk(rd_q & 8'h02, 8'h02);
    repeat (10) begin
      rx_data = ~rx_data;
      tick(3);
    end
    chk(optical_input_lost, 8'h00);
    rd(8'h6e);
    chk(rd_q & 8'h02, 8'h00);
  endtask
  task automatic print_verdict;
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    tick(6);
    arst_n = 1'b1;
    t_pin();
    t_soft();
    t_fault(1'b0);
    t_fault(1'b1);
    t_los();
    print_verdict();
  end
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule
bind optical_ctl optical_ctl_sva #(.LOS_WINDOW(LOS_WINDOW)) u_optical_ctl_sva (
  .sys_clk            (sys_clk),
  .arst_n             (arst_n),
  .txoff_pin          (txoff_pin),
  .rx_data            (rx_data),
  .laser_fault_det    (laser_fault_det),
  .power_unsafe_det   (power_unsafe_det),
  .diag_wr            (diag_wr),
  .diag_rd            (diag_rd),
  .diag_addr          (diag_addr),
  .diag_wdata         (diag_wdata),
  .diag_rdata         (diag_rdata),
  .laser_enable       (laser_enable),
  .tx_fault_oe        (tx_fault_oe),
  .tx_fault           (tx_fault),
  .optical_input_lost (optical_input_lost)
);
